// >>> rtl/tis_defines.svh
// Register offsets, flag positions and reset values of the threshold and interrupt status block.
// Assumes it is included by bare name from the rtl/ directory.
`ifndef TIS_DEFINES_SVH
`define TIS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TIS_REG_LOW_UPPER   8'h8A
`define TIS_REG_LOW_LOWER   8'h8B
`define TIS_REG_HIGH_UPPER  8'h8C
`define TIS_REG_HIGH_LOWER  8'h8D
`define TIS_REG_FLAGS       8'h8E

// ----------------------------------------------------------------------------
// Flag positions in the status register
// ----------------------------------------------------------------------------
`define TIS_FLAG_PROX       3
`define TIS_FLAG_ALS        2
`define TIS_FLAG_LOW        1
`define TIS_FLAG_HIGH       0
`define TIS_FLAG_W          4
`define TIS_FLAG_PAD        4'h0

// ----------------------------------------------------------------------------
// Reset values and bus constants
// ----------------------------------------------------------------------------
`define TIS_BYTE_RST        8'h00
`define TIS_FLAGS_RST       4'h0
`define TIS_RD_UNMAPPED     8'h00
`define TIS_BITS_PER_BYTE   4'h8
`define TIS_BITCNT_RST      4'h0
`define TIS_BITCNT_ONE      4'h1
`define TIS_I2C_ADDR_DEF    7'h13

`endif

// >>> rtl/tis_flags.sv
// Threshold registers, threshold comparison and sticky interrupt flags.
// Assumes register writes and measurement events come from logic on clk.
`timescale 1ns/1ns
`default_nettype none
`include "tis_defines.svh"

module tis_flags (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  reg_wr,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    input  wire logic                  prox_done,
    input  wire logic [15:0]           prox_result,
    input  wire logic                  als_done,
    input  wire logic [15:0]           als_result,
    input  wire logic                  prox_irq_enable,
    input  wire logic                  als_irq_enable,
    input  wire logic                  limit_irq_enable,
    input  wire logic                  limit_source_select,
    output logic [`TIS_FLAG_W-1:0]     flags
);

    logic [15:0]             low_q;
    logic [15:0]             low_d;
    logic [15:0]             high_q;
    logic [15:0]             high_d;
    logic [`TIS_FLAG_W-1:0]  flags_q;
    logic [`TIS_FLAG_W-1:0]  flags_d;
    logic [`TIS_FLAG_W-1:0]  set_ev;
    logic [`TIS_FLAG_W-1:0]  clr_ev;
    logic                    sel_done;
    logic [15:0]             sel_val;

    function automatic logic hit(input logic wr, input logic [7:0] a, input logic [7:0] r);
        hit = wr && (a == r);
    endfunction

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        low_d  = low_q;
        high_d = high_q;
        if (hit(reg_wr, reg_addr, `TIS_REG_LOW_UPPER)) begin
            low_d[15:8] = reg_wdata;
        end
        if (hit(reg_wr, reg_addr, `TIS_REG_LOW_LOWER)) begin
            low_d[7:0] = reg_wdata;
        end
        if (hit(reg_wr, reg_addr, `TIS_REG_HIGH_UPPER)) begin
            high_d[15:8] = reg_wdata;
        end
        if (hit(reg_wr, reg_addr, `TIS_REG_HIGH_LOWER)) begin
            high_d[7:0] = reg_wdata;
        end

        sel_done = limit_source_select ? als_done : prox_done;
        sel_val  = limit_source_select ? als_result : prox_result;

        set_ev                 = `TIS_FLAGS_RST;
        set_ev[`TIS_FLAG_PROX] = prox_done && prox_irq_enable;
        set_ev[`TIS_FLAG_ALS]  = als_done && als_irq_enable;
        set_ev[`TIS_FLAG_LOW]  = limit_irq_enable && sel_done && (sel_val < low_q);
        set_ev[`TIS_FLAG_HIGH] = limit_irq_enable && sel_done && (sel_val > high_q);

        clr_ev = `TIS_FLAGS_RST;
        if (hit(reg_wr, reg_addr, `TIS_REG_FLAGS)) begin
            clr_ev = reg_wdata[`TIS_FLAG_W-1:0];
        end
        flags_d = (flags_q & ~clr_ev) | set_ev;
    end

    // ------------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------------
    always_comb begin
        unique case (reg_addr)
            `TIS_REG_LOW_UPPER:  reg_rdata = low_q[15:8];
            `TIS_REG_LOW_LOWER:  reg_rdata = low_q[7:0];
            `TIS_REG_HIGH_UPPER: reg_rdata = high_q[15:8];
            `TIS_REG_HIGH_LOWER: reg_rdata = high_q[7:0];
            `TIS_REG_FLAGS:      reg_rdata = {`TIS_FLAG_PAD, flags_q};
            default:             reg_rdata = `TIS_RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_q   <= {`TIS_BYTE_RST, `TIS_BYTE_RST};
            high_q  <= {`TIS_BYTE_RST, `TIS_BYTE_RST};
            flags_q <= `TIS_FLAGS_RST;
        end else begin
            low_q   <= low_d;
            high_q  <= high_d;
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;

endmodule // tis_flags

`default_nettype wire

// >>> rtl/tis_pkg.sv
// Types shared by the threshold and interrupt status block.
// Assumes nothing of its surroundings.
package tis_pkg;

    typedef enum logic [3:0] {
        TIS_ST_IDLE,
        TIS_ST_ADDR,
        TIS_ST_ACK_ADDR,
        TIS_ST_PTR,
        TIS_ST_ACK_PTR,
        TIS_ST_WDATA,
        TIS_ST_ACK_W,
        TIS_ST_RDATA,
        TIS_ST_ACK_R
    } tis_state_e;

endpackage

// >>> rtl/tis_top.sv
// Threshold comparison and interrupt status block with its I2C register slave.
// Assumes measurement events and enables come from logic on clk; scl and sda are pins.
`timescale 1ns/1ns
`default_nettype none
`include "tis_defines.svh"

module tis_top #(
    parameter logic [6:0] I2C_ADDR = `TIS_I2C_ADDR_DEF
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          scl_i,
    input  wire logic          sda_i,
    output logic               sda_o,
    output logic               sda_oe,
    output logic               int_n,
    input  wire logic          prox_done,
    input  wire logic [15:0]   prox_result,
    input  wire logic          als_done,
    input  wire logic [15:0]   als_result,
    input  wire logic          prox_irq_enable,
    input  wire logic          als_irq_enable,
    input  wire logic          limit_irq_enable,
    input  wire logic          limit_source_select
);

    logic [2:0]               scl_sync_q;
    logic [2:0]               sda_sync_q;
    logic                     scl_rise;
    logic                     scl_fall;
    logic                     start_cond;
    logic                     stop_cond;

    tis_pkg::tis_state_e      state_q;
    tis_pkg::tis_state_e      state_d;
    logic [3:0]               cnt_q;
    logic [3:0]               cnt_d;
    logic [7:0]               shift_q;
    logic [7:0]               shift_d;
    logic [7:0]               tx_q;
    logic [7:0]               tx_d;
    logic [7:0]               ptr_q;
    logic [7:0]               ptr_d;
    logic                     oe_q;
    logic                     oe_d;
    logic                     acked_q;
    logic                     acked_d;
    logic                     wr_q;
    logic                     wr_d;
    logic [7:0]               wdata_q;
    logic [7:0]               wdata_d;
    logic                     int_n_q;
    logic                     int_n_d;
    logic [7:0]               rdata;
    logic [`TIS_FLAG_W-1:0]   flags;

    // ------------------------------------------------------------------------
    // Pin synchronisers and bus condition detection
    // ------------------------------------------------------------------------
    // Bit 0 is the metastability stage; bit 1 feeds bit 2, and bits 1 and 2 both feed the logic.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], scl_i};
            sda_sync_q <= {sda_sync_q[1:0], sda_i};
        end
    end

    assign scl_rise   = scl_sync_q[1] && !scl_sync_q[2];
    assign scl_fall   = !scl_sync_q[1] && scl_sync_q[2];
    assign start_cond = scl_sync_q[1] && scl_sync_q[2] && !sda_sync_q[1] && sda_sync_q[2];
    assign stop_cond  = scl_sync_q[1] && scl_sync_q[2] && sda_sync_q[1] && !sda_sync_q[2];

    // ------------------------------------------------------------------------
    // Register block
    // ------------------------------------------------------------------------
    tis_flags u_flags (
        .clk                 (clk),
        .rst_n               (rst_n),
        .reg_wr              (wr_q),
        .reg_addr            (ptr_q),
        .reg_wdata           (wdata_q),
        .reg_rdata           (rdata),
        .prox_done           (prox_done),
        .prox_result         (prox_result),
        .als_done            (als_done),
        .als_result          (als_result),
        .prox_irq_enable     (prox_irq_enable),
        .als_irq_enable      (als_irq_enable),
        .limit_irq_enable    (limit_irq_enable),
        .limit_source_select (limit_source_select),
        .flags               (flags)
    );

    // ------------------------------------------------------------------------
    // I2C slave next state
    // ------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        shift_d = shift_q;
        tx_d    = tx_q;
        ptr_d   = ptr_q;
        oe_d    = oe_q;
        acked_d = acked_q;
        wr_d    = 1'b0;
        wdata_d = wdata_q;
        // The write strobe lasts one cycle; the pointer steps only after it.
        if (wr_q) begin
            ptr_d = ptr_q + 8'h01;
        end
        if (start_cond) begin
            state_d = tis_pkg::TIS_ST_ADDR;
            cnt_d   = `TIS_BITCNT_RST;
            oe_d    = 1'b0;
        end else if (stop_cond) begin
            state_d = tis_pkg::TIS_ST_IDLE;
            oe_d    = 1'b0;
        end else begin
            unique case (state_q)
                tis_pkg::TIS_ST_IDLE: begin
                    oe_d = 1'b0;
                end
                tis_pkg::TIS_ST_ADDR, tis_pkg::TIS_ST_PTR, tis_pkg::TIS_ST_WDATA: begin
                    if (scl_rise && cnt_q != `TIS_BITS_PER_BYTE) begin
                        shift_d = {shift_q[6:0], sda_sync_q[1]};
                        cnt_d   = cnt_q + `TIS_BITCNT_ONE;
                    end else if (scl_fall && cnt_q == `TIS_BITS_PER_BYTE) begin
                        cnt_d = `TIS_BITCNT_RST;
                        oe_d  = 1'b1;
                        if (state_q == tis_pkg::TIS_ST_ADDR) begin
                            if (shift_q[7:1] == I2C_ADDR) begin
                                acked_d = shift_q[0];
                                state_d = tis_pkg::TIS_ST_ACK_ADDR;
                            end else begin
                                oe_d    = 1'b0;
                                state_d = tis_pkg::TIS_ST_IDLE;
                            end
                        end else if (state_q == tis_pkg::TIS_ST_PTR) begin
                            ptr_d   = shift_q;
                            state_d = tis_pkg::TIS_ST_ACK_PTR;
                        end else begin
                            wr_d    = 1'b1;
                            wdata_d = shift_q;
                            state_d = tis_pkg::TIS_ST_ACK_W;
                        end
                    end
                end
                tis_pkg::TIS_ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (acked_q) begin
                            tx_d    = rdata;
                            oe_d    = !rdata[7];
                            cnt_d   = `TIS_BITCNT_ONE;
                            state_d = tis_pkg::TIS_ST_RDATA;
                        end else begin
                            oe_d    = 1'b0;
                            state_d = tis_pkg::TIS_ST_PTR;
                        end
                    end
                end
                tis_pkg::TIS_ST_ACK_PTR, tis_pkg::TIS_ST_ACK_W: begin
                    if (scl_fall) begin
                        oe_d    = 1'b0;
                        state_d = tis_pkg::TIS_ST_WDATA;
                    end
                end
                tis_pkg::TIS_ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_q == `TIS_BITS_PER_BYTE) begin
                            oe_d    = 1'b0;
                            acked_d = 1'b0;
                            state_d = tis_pkg::TIS_ST_ACK_R;
                        end else begin
                            tx_d  = {tx_q[6:0], 1'b0};
                            oe_d  = !tx_q[6];
                            cnt_d = cnt_q + `TIS_BITCNT_ONE;
                        end
                    end
                end
                tis_pkg::TIS_ST_ACK_R: begin
                    if (scl_rise) begin
                        acked_d = !sda_sync_q[1];
                        if (!sda_sync_q[1]) begin
                            ptr_d = ptr_q + 8'h01;
                        end
                    end else if (scl_fall) begin
                        if (acked_q) begin
                            tx_d    = rdata;
                            oe_d    = !rdata[7];
                            cnt_d   = `TIS_BITCNT_ONE;
                            state_d = tis_pkg::TIS_ST_RDATA;
                        end else begin
                            state_d = tis_pkg::TIS_ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = tis_pkg::TIS_ST_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
        end
        int_n_d = !(|flags);
    end

    // ------------------------------------------------------------------------
    // I2C slave registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= tis_pkg::TIS_ST_IDLE;
            cnt_q   <= `TIS_BITCNT_RST;
            shift_q <= `TIS_BYTE_RST;
            tx_q    <= `TIS_BYTE_RST;
            ptr_q   <= `TIS_BYTE_RST;
            oe_q    <= 1'b0;
            acked_q <= 1'b0;
            wr_q    <= 1'b0;
            wdata_q <= `TIS_BYTE_RST;
            int_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            shift_q <= shift_d;
            tx_q    <= tx_d;
            ptr_q   <= ptr_d;
            oe_q    <= oe_d;
            acked_q <= acked_d;
            wr_q    <= wr_d;
            wdata_q <= wdata_d;
            int_n_q <= int_n_d;
        end
    end

    assign sda_o  = 1'b0;
    assign sda_oe = oe_q;
    assign int_n  = int_n_q;

endmodule // tis_top

`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench of the threshold and interrupt status block.
// Assumes the host model in tis_host.sv and the bound checker.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    localparam logic [6:0] DEV = 7'h13;
    logic        clk, rst_n, scl, sda_drv, sda, sda_o, sda_oe, int_n, hi_seen;
    logic        prox_done, als_done, pe, ae, le, sel;
    logic [15:0] prox_result, als_result, lo, hi;
    logic [31:0] th, rv;
    logic [7:0]  rdv;
    logic [3:0]  exp_flags;
    logic [2:0]  nk;
    int          failures, n_tests, cycles;
    integer      seed;

    assign sda = sda_drv & ~(sda_oe & ~sda_o);

    tis_top #(.I2C_ADDR(DEV)) DUT (
        .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .int_n(int_n), .prox_done(prox_done), .prox_result(prox_result), .als_done(als_done),
        .als_result(als_result), .prox_irq_enable(pe), .als_irq_enable(ae),
        .limit_irq_enable(le), .limit_source_select(sel)
    );

    tis_host #(.DEV(DEV)) host (.clk(clk), .sda_in(sda), .scl(scl), .sda_drv(sda_drv));

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            results();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        n_tests++;
        if (seen !== want) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Flags that one cycle of done pulses should set, from the current enables.
    function automatic logic [3:0] ev_set(input logic pd, input logic ad);
        logic [15:0] v;
        logic        d;
        v = sel ? als_result : prox_result;
        d = (sel ? ad : pd) & le;
        return {pd & pe, ad & ae, d & (v < lo), d & (v > hi)};
    endfunction

    initial begin
        {clk, rst_n, prox_done, als_done, pe, ae, le, sel} = 8'h00;
        {prox_result, als_result} = 32'h0;
        {failures, n_tests, cycles} = '0;
        exp_flags = 4'h0;
        seed = 32'hf8e8a3da;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        for (int a = 0; a < 6; a++) begin
            host.rd(8'h8A + 8'(a), rdv);
            check("reset value", rdv, 8'h00);
        end
        rv = $random(seed);
        lo = {4'h4, rv[11:0]};
        hi = {4'hB, rv[27:16]};
        th = {lo, hi};
        for (int i = 0; i < 4; i++) begin
            host.wr(DEV, 8'h8A + 8'(i), th[31 - 8 * i -: 8], nk);
            check("write ack", {5'h00, nk}, 8'h00);
            host.rd(8'h8A + 8'(i), rdv);
            check("threshold byte", rdv, th[31 - 8 * i -: 8]);
        end
        host.wr(DEV ^ 7'h01, 8'h8A, ~lo[15:8], nk);
        check("foreign address", {5'h00, nk}, 8'h07);
        host.rd(8'h8A, rdv);
        check("kept byte", rdv, lo[15:8]);
        for (int k = 0; k < 14; k++) begin
            rv = $random(seed);
            {pe, ae, le, sel, als_done, prox_done} = rv[5:0];
            {prox_result, als_result} = $random(seed);
            if (k < 4) begin
                {pe, ae, le, sel, als_done, prox_done} = 6'h39;
                prox_result = (k == 0) ? lo : (k == 1) ? hi : (k == 2) ? lo - 16'h1 : hi + 16'h1;
            end
            exp_flags = exp_flags | ev_set(prox_done, als_done);
            @(negedge clk);
            {als_done, prox_done} = 2'h0;
            repeat (2) @(negedge clk);
            check("int pin", {7'h00, int_n}, {7'h00, ~|exp_flags});
            host.rd(8'h8E, rdv);
            check("status", rdv, {4'h0, exp_flags});
            rv = $random(seed);
            host.wr(DEV, 8'h8E, rv[7:0], nk);
            exp_flags = exp_flags & ~rv[3:0];
            repeat (4) @(negedge clk);
            check("int after clear", {7'h00, int_n}, {7'h00, ~|exp_flags});
        end
        // A clear that meets a held proximity event must not lose the flag.
        {pe, le, prox_done} = 3'h5;
        repeat (3) @(negedge clk);
        hi_seen = 1'b0;
        fork
            host.wr(DEV, 8'h8E, 8'h0F, nk);
            repeat (560) begin
                @(negedge clk);
                hi_seen = hi_seen | (int_n !== 1'b0);
            end
        join
        check("int held low", {7'h00, hi_seen}, 8'h00);
        prox_done = 1'b0;
        host.rd(8'h8E, rdv);
        check("status kept", rdv, 8'h08);
        host.wr(DEV, 8'h8E, 8'h08, nk);
        host.rd(8'h8E, rdv);
        check("status cleared", rdv, 8'h00);
        check("int released", {7'h00, int_n}, 8'h01);
        results();
    end
endmodule // tb_top

`default_nettype wire

// >>> tb/tis_checker.sv
// Checker of the threshold and interrupt status block, bound to its top module.
// Assumes one clk domain and the active-low asynchronous rst_n.
`timescale 1ns/1ns
`default_nettype none

module tis_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        scl_i,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe,
    input wire logic        int_n,
    input wire logic        prox_done,
    input wire logic [15:0] prox_result,
    input wire logic        als_done,
    input wire logic [15:0] als_result,
    input wire logic        prox_irq_enable,
    input wire logic        als_irq_enable,
    input wire logic        limit_irq_enable,
    input wire logic        limit_source_select
);
    logic [7:0] fall_cnt_q;
    logic [7:0] fall_cnt_d;
    logic       scl_q;
    logic       ev_any;

    // Counts cycles since SCL was last seen falling, saturating.
    always_comb begin
        fall_cnt_d = (fall_cnt_q == 8'hFF) ? 8'hFF : fall_cnt_q + 8'h01;
        if (scl_q && !scl_i) begin
            fall_cnt_d = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_cnt_q <= 8'hFF;
            scl_q      <= 1'b1;
        end else begin
            fall_cnt_q <= fall_cnt_d;
            scl_q      <= scl_i;
        end
    end

    assign ev_any = (prox_done && prox_irq_enable) || (als_done && als_irq_enable)
                  || (limit_irq_enable && (limit_source_select ? als_done : prox_done));

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_prox_sets_int: assert property (prox_done && prox_irq_enable |-> ##2 !int_n)
        else $error("int_n not low after a proximity event");
    a_als_sets_int: assert property (als_done && als_irq_enable |-> ##2 !int_n)
        else $error("int_n not low after an ambient event");
    a_int_has_cause: assert property ($fell(int_n) |-> $past(ev_any, 2))
        else $error("int_n fell without an enabled event");
    a_flag_stays_set: assert property (prox_done && prox_irq_enable && fall_cnt_q > 8'h10
        |-> ##2 (!int_n) [*3])
        else $error("flag did not stay set");
    a_clear_by_bus: assert property ($rose(int_n) |-> fall_cnt_q <= 8'h0A)
        else $error("int_n released without a bus write");
    a_oe_after_fall: assert property ($changed(sda_oe) |-> fall_cnt_q <= 8'h06)
        else $error("sda_oe changed away from an SCL fall");
    a_oe_steady_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
        else $error("sda_oe changed while SCL high");
    a_sda_o_low: assert property (sda_oe |-> sda_o == 1'b0)
        else $error("sda_o not low while driven");
endmodule // tis_checker

bind tis_top tis_checker u_chk (
    .clk(clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .int_n(int_n), .prox_done(prox_done), .prox_result(prox_result),
    .als_done(als_done), .als_result(als_result), .prox_irq_enable(prox_irq_enable),
    .als_irq_enable(als_irq_enable), .limit_irq_enable(limit_irq_enable),
    .limit_source_select(limit_source_select)
);

`default_nettype wire

// >>> tb/tis_host.sv
// I2C host model that reaches the block's registers.
// Assumes the bench resolves SDA with a pull-up from sda_drv and the block's enable.
`timescale 1ns/1ns
`default_nettype none

module tis_host #(
    parameter logic [6:0] DEV = 7'h13
) (
    input  wire logic clk,
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic hp();
        repeat (6) @(negedge clk);
    endtask

    // Start when stop is 0, stop when it is 1; a start from SCL low is a repeated start.
    task automatic cond(input logic stop);
        sda_drv = stop ? 1'b0 : 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sda_drv = stop;
        hp();
        scl = stop;
        hp();
    endtask

    // Sends eight bits and the ninth, and returns what the line carried in each.
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [8:0] rx);
        rx = {tx, last};
        for (int i = 8; i >= 0; i--) begin
            sda_drv = rx[i];
            hp();
            scl = 1'b1;
            hp();
            rx[i] = sda_in;
            scl = 1'b0;
            hp();
        end
        sda_drv = 1'b1;
    endtask

    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] val,
                      output logic [2:0] nacks);
        logic [8:0] r0;
        logic [8:0] r1;
        logic [8:0] r2;
        cond(1'b0);
        xfer({dev, 1'b0}, 1'b1, r0);
        xfer(ptr, 1'b1, r1);
        xfer(val, 1'b1, r2);
        cond(1'b1);
        nacks = {r0[0], r1[0], r2[0]};
    endtask

    task automatic rd(input logic [7:0] ptr, output logic [7:0] val);
        logic [8:0] r;
        cond(1'b0);
        xfer({DEV, 1'b0}, 1'b1, r);
        xfer(ptr, 1'b1, r);
        cond(1'b0);
        xfer({DEV, 1'b1}, 1'b1, r);
        xfer(8'hFF, 1'b1, r);
        val = r[8:1];
        cond(1'b1);
    endtask
endmodule // tis_host

`default_nettype wire
